// *** logic_function_elements.sv ***
/*
  Logic function elements: pulse counter, sixteen on/off delays, edge
  pulse, latch with front-panel clear and analog comparator, with a
  classic Wishbone register slave.
  Assumes pins arrive asynchronously and the measurement changes slowly
  against the millisecond logic cycle.
*/
// Overview of operation
// RULE_01: Each rising count input adds one to the stored count.
// RULE_02: Counter output is high while count is at or above trigger.
// RULE_03: Counter reset input clears the stored count to zero.
// RULE_04: Each delay has separate rise and fall times in milliseconds.
// RULE_05: Output rises after input high for rise time, holds for fall time.
// RULE_06: At most sixteen delay elements run at once.
// RULE_07: Edge element emits one 5 ms pulse on the chosen transition.
// RULE_08: Polarity select high picks rising transitions of the source.
// RULE_09: Polarity select low picks falling transitions of the source.
// RULE_10: Longer pulses are made by cascading edge into a delay element.
// RULE_11: Latch sets on set input, back button clears, set dominates.
// RULE_12: Comparator output follows the chosen relation of measurement to value.
// RULE_13: Six operators: equal, not equal, less, greater, less-equal, greater-equal.
// RULE_14: Edge output stays low while the source input is steady.
// RULE_15: Input pulses shorter than the rise time never reach the output.
// RULE_16: All elements step once per logic cycle on a millisecond base.
`timescale 1ns/1ns
`default_nettype none

module logic_function_elements #(
  parameter int unsigned TICK_CYCLES = logic_pkg::CYCLES_PER_MS,
  parameter int unsigned DELAYS      = logic_pkg::DELAY_SLOTS
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              countPulseIn,
  input  wire logic              countReset,
  input  wire logic              edgeSource,
  input  wire logic              edgePolarity,
  input  wire logic              latchSet,
  input  wire logic              backButton,
  input  wire logic [31:0]       measurement,
  input  wire logic [DELAYS-1:0] delayIn,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [31:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   counterOut,
  output logic                   edgeOut,
  output logic                   latchOut,
  output logic                   compareOut,
  output logic [DELAYS-1:0]      delayOut
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam int PW = 38 + DELAYS;
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST  = TW'(TICK_CYCLES - 1);
  localparam logic [2:0]    EDGE_TICKS = 3'(logic_pkg::EDGE_PULSE_TICKS);

  typedef struct packed {
    logic [PW-1:0]            syncA;
    logic [PW-1:0]            syncB;
    logic [TW-1:0]            divCount;
    logic                     tick;
    logic                     countPrev;
    logic [31:0]              count;
    logic                     counterOut;
    logic                     edgePrev;
    logic [2:0]               pulseLeft;
    logic                     edgeOut;
    logic                     latchOut;
    logic                     compareOut;
    logic [31:0]              trig;
    logic [2:0]               cmpOp;
    logic [31:0]              cmpValue;
    logic [DELAYS-1:0]        delayEn;
    logic [DELAYS-1:0][31:0]  delayTime;
    logic                     ack;
    logic [31:0]              datO;
  } core_type;

  core_type s;
  core_type next_s;

  // Synchronised pin fields, read from the second stage only
  logic              cPulse;
  logic              cReset;
  logic              eSrc;
  logic              ePol;
  logic              lSet;
  logic              lBack;
  logic [31:0]       meas;
  logic [DELAYS-1:0] dIn;
  logic [DELAYS-1:0] dHeld;
  logic              edgeHit;
  logic              request;
  logic              mapped;
  logic [7:0]        ofs;

  assign {dIn, meas, cPulse, cReset, eSrc, ePol, lSet, lBack} = s.syncB;

  // Edge detection compares the current and previous logic-cycle samples
  // The previous sample moves only on ticks, so a steady input never fires
  assign edgeHit = ePol ? (eSrc && !s.edgePrev) : (!eSrc && s.edgePrev);  // RULE_14

  // Only the low byte picks a register; any upper bit set makes the access
  // unmapped, which is still acknowledged but reads zero
  assign request = wb_cyc_i && wb_stb_i;
  assign mapped  = (wb_adr_i[31:8] == 24'h0);
  assign ofs     = wb_adr_i[7:0];

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Six operators; the two spare codes never assert the output
  function automatic logic compare(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b);
    unique case (op)
      logic_pkg::OP_EQ: compare = (a == b);  // RULE_13
      logic_pkg::OP_NE: compare = (a != b);
      logic_pkg::OP_LT: compare = ($signed(a) < $signed(b));
      logic_pkg::OP_GT: compare = ($signed(a) > $signed(b));
      logic_pkg::OP_LE: compare = ($signed(a) <= $signed(b));
      logic_pkg::OP_GE: compare = ($signed(a) >= $signed(b));
      default:          compare = 1'b0;
    endcase
  endfunction : compare

  // Byte-lane merge of a write under the select bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
  endfunction : merge

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Two-stage synchronisers on every pin
    next_s.syncA = {delayIn, measurement, countPulseIn, countReset, edgeSource, edgePolarity, latchSet, backButton};
    next_s.syncB = s.syncA;

    // Millisecond logic-cycle divider; one registered tick steps every
    // element, so all of them share the same time base
    next_s.tick = 1'b0;
    if (s.divCount == TICK_LAST) begin
      next_s.divCount = '0;
      next_s.tick     = 1'b1;  // RULE_16
    end else begin
      next_s.divCount = s.divCount + TW'(1);
    end

    // Elements step only on the logic-cycle tick
    if (s.tick) begin
      // Saturating at all-ones keeps a stuck input from wrapping the count
      // Counter: reset wins over a count arriving in the same cycle
      if (cReset) begin
        next_s.count = '0;  // RULE_03
      end else if (cPulse && !s.countPrev && s.count != '1) begin
        next_s.count = s.count + 32'h1;  // RULE_01
      end
      next_s.countPrev  = cPulse;
      next_s.counterOut = (next_s.count >= s.trig);  // RULE_02

      // Edge pulse: a new edge during a pulse restarts it
      if (edgeHit) begin
        next_s.pulseLeft = EDGE_TICKS;  // RULE_07 RULE_08 RULE_09
      end else if (s.pulseLeft != 3'h0) begin
        next_s.pulseLeft = s.pulseLeft - 3'h1;
      end
      next_s.edgeOut  = (next_s.pulseLeft != 3'h0);
      next_s.edgePrev = eSrc;

      // Latch: a high set keeps the output up even with the button held
      next_s.latchOut = lSet || (s.latchOut && !lBack);  // RULE_11

      next_s.compareOut = compare(s.cmpOp, meas, s.cmpValue);  // RULE_12
    end

    // Classic Wishbone: ack one cycle after the request, dropped after one
    // Read data is captured when the request is taken and then held, so
    // the master takes it at the ack edge with no second decode
    next_s.ack = request && !s.ack;
    if (request && !s.ack) begin
      next_s.datO = 32'h0;
      if (mapped) begin
        unique case (ofs)
          logic_pkg::TRIGGER_OFS:   next_s.datO = s.trig;
          logic_pkg::COUNT_OFS:     next_s.datO = s.count;
          logic_pkg::CMP_OP_OFS:    next_s.datO = {29'h0, s.cmpOp};
          logic_pkg::CMP_VALUE_OFS: next_s.datO = s.cmpValue;
          logic_pkg::STATUS_OFS: begin
            next_s.datO = {28'h0, s.compareOut, s.latchOut, s.edgeOut, s.counterOut};
            next_s.datO[logic_pkg::STATUS_DELAY_LSB +: DELAYS] = dHeld;
          end
          logic_pkg::DELAY_EN_OFS:  next_s.datO[DELAYS-1:0] = s.delayEn;
          default: begin
            if (ofs[7:6] == logic_pkg::DELAY_TIME_SEG && 32'(ofs[5:2]) < DELAYS) begin
              next_s.datO = s.delayTime[ofs[5:2]];
            end
          end
        endcase
      end
    end

    // Writes land on the edge where the master samples ack
    // COUNT and STATUS have no write case, so writes to them are dropped
    if (request && s.ack && wb_we_i && mapped) begin
      unique case (ofs)
        logic_pkg::TRIGGER_OFS:   next_s.trig = merge(s.trig, wb_dat_i, wb_sel_i);
        logic_pkg::CMP_OP_OFS:    next_s.cmpOp = wb_sel_i[0] ? wb_dat_i[2:0] : s.cmpOp;
        logic_pkg::CMP_VALUE_OFS: next_s.cmpValue = merge(s.cmpValue, wb_dat_i, wb_sel_i);
        logic_pkg::DELAY_EN_OFS: begin
          next_s.delayEn = DELAYS'(merge(32'(s.delayEn), wb_dat_i, wb_sel_i));  // RULE_06
        end
        default: begin
          if (ofs[7:6] == logic_pkg::DELAY_TIME_SEG && 32'(ofs[5:2]) < DELAYS) begin
            next_s.delayTime[ofs[5:2]] = merge(s.delayTime[ofs[5:2]], wb_dat_i, wb_sel_i);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s          <= '0;
      s.trig     <= logic_pkg::TRIGGER_RESET;
      s.cmpValue <= logic_pkg::CMP_VALUE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Delay elements
  // ----------------------------------------------------------------------
  // One element per slot; the slot count caps how many can be in use
  // Every slot shares the engine tick, so all delays count the same ms
  for (genvar i = 0; i < DELAYS; i++) begin : gen_delay
    delay_link_if link ();
    assign link.tick   = s.tick;  // RULE_16
    assign link.enable = s.delayEn[i];  // RULE_06
    assign link.level  = dIn[i];
    assign link.riseMs = s.delayTime[i][logic_pkg::RISE_LSB +: logic_pkg::DELAY_MS_W];
    assign link.fallMs = s.delayTime[i][logic_pkg::FALL_LSB +: logic_pkg::DELAY_MS_W];
    assign dHeld[i]    = link.held;

    delay_element u_delay (
      .clk    (clk),
      .resetn (resetn),
      .link   (link.element)
    );
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // All registered: core state here, the held bit inside each slot
  assign wb_dat_o   = s.datO;
  assign wb_ack_o   = s.ack;
  assign counterOut = s.counterOut;
  assign edgeOut    = s.edgeOut;
  assign latchOut   = s.latchOut;
  assign compareOut = s.compareOut;
  assign delayOut   = dHeld;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Counter
  count_step_a: assert property (s.tick && cPulse && !s.countPrev && !cReset && s.count != '1 // RULE_01
      |=> s.count == $past(s.count) + 32'h1)
    else $error("count did not step on a rising count input");
  count_hold_a: assert property (s.tick && !(cPulse && !s.countPrev) && !cReset // RULE_01
      |=> s.count == $past(s.count))
    else $error("count moved without a rising count input");
  count_out_a: assert property (s.tick ##1 $stable(s.trig) |-> s.counterOut == (s.count >= s.trig)) // RULE_02
    else $error("counter output disagrees with count and trigger");
  count_clear_a: assert property (s.tick && cReset |=> s.count == 32'h0) // RULE_03
    else $error("counter reset did not clear the count");

  // Edge pulse
  edge_load_a: assert property ($rose(s.edgeOut) |-> s.pulseLeft == EDGE_TICKS) // RULE_07
    else $error("edge pulse did not start at full length");
  edge_rise_a: assert property (s.tick && ePol && eSrc && !s.edgePrev |=> s.edgeOut) // RULE_08
    else $error("rising edge missed with polarity high");
  edge_fall_a: assert property (s.tick && !ePol && !eSrc && s.edgePrev |=> s.edgeOut) // RULE_09
    else $error("falling edge missed with polarity low");
  edge_quiet_a: assert property (s.tick && !edgeHit && s.pulseLeft == 3'h0 |=> !s.edgeOut) // RULE_14
    else $error("edge output rose without a transition");

  // Latch and comparator
  latch_set_a: assert property (s.tick && lSet |=> s.latchOut) // RULE_11
    else $error("latch not set while set input high");
  latch_clear_a: assert property (s.tick && !lSet && lBack |=> !s.latchOut) // RULE_11
    else $error("back button did not clear the latch");
  cmp_result_a: assert property (s.tick ##1 $stable(s.cmpOp) && $stable(s.cmpValue) // RULE_12
      |-> s.compareOut == compare(s.cmpOp, $past(meas), s.cmpValue))
    else $error("comparator output disagrees with the relation");
  cmp_spare_a: assert property (s.tick && s.cmpOp > logic_pkg::OP_GE |=> !s.compareOut) // RULE_13
    else $error("spare operator code asserted the comparator");
  tick_gap_a: assert property (s.tick |=> !s.tick) // RULE_16
    else $error("logic-cycle tick lasted more than one clock");

  // Between ticks the count and the counter, edge, latch and comparator outputs hold; a stray update would break the time base
  step_only_a: assert property (!s.tick |=> // RULE_16
      $stable({s.count, s.counterOut, s.edgeOut, s.latchOut, s.compareOut}))
    else $error("element state moved between ticks");
  edge_restart_a: assert property (s.tick && edgeHit |=> s.pulseLeft == EDGE_TICKS) // RULE_07
    else $error("edge pulse did not restart on a transition");
  edge_end_a: assert property (s.tick && !edgeHit && s.pulseLeft == 3'h1 |=> !s.edgeOut) // RULE_07
    else $error("edge pulse outlasted its length");
  latch_keep_a: assert property (s.tick && !lSet && !lBack |=> s.latchOut == $past(s.latchOut)) // RULE_11
    else $error("latch moved with set and button low");
  delay_off_a: assert property ((dHeld & ~$past(s.delayEn)) == '0) // RULE_06
    else $error("disabled delay slot drove its output");

  edge_pulse_c:  cover property (s.tick && edgeHit ##1 s.edgeOut);
  latch_hold_c:  cover property (s.latchOut && !lSet && !lBack);
  count_trip_c:  cover property ($rose(s.counterOut));
  compare_on_c:  cover property ($rose(s.compareOut));
  delay_out_c:   cover property ($fell(dHeld[1]));

endmodule : logic_function_elements

`default_nettype wire

// *** logic_pkg.sv ***
/*
  Shared constants for the logic function elements: time base, register
  offsets, field positions, reset values and comparator operator codes.
  Assumes a single 100 MHz clock and a 32-bit classic Wishbone register bus.
*/
`default_nettype none

package logic_pkg;

  // ----------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------
  localparam int unsigned CLOCK_HZ         = 100_000_000;
  localparam int unsigned MS_PER_SECOND    = 1000;
  localparam int unsigned LOGIC_CYCLE_MS   = 1;
  localparam int unsigned CYCLES_PER_MS    = CLOCK_HZ / MS_PER_SECOND * LOGIC_CYCLE_MS;
  localparam int unsigned EDGE_PULSE_MS    = 5;
  localparam int unsigned EDGE_PULSE_TICKS = EDGE_PULSE_MS / LOGIC_CYCLE_MS;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned DELAY_SLOTS = 16;
  localparam int unsigned DELAY_MS_W  = 16;

  // ----------------------------------------------------------------------
  // Register byte offsets and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] TRIGGER_OFS    = 8'h00;
  localparam logic [7:0] COUNT_OFS      = 8'h04;
  localparam logic [7:0] CMP_OP_OFS     = 8'h08;
  localparam logic [7:0] CMP_VALUE_OFS  = 8'h0c;
  localparam logic [7:0] STATUS_OFS     = 8'h10;
  localparam logic [7:0] DELAY_EN_OFS   = 8'h14;
  localparam logic [1:0] DELAY_TIME_SEG = 2'h1;
  localparam int unsigned RISE_LSB         = 0;
  localparam int unsigned FALL_LSB         = 16;
  localparam int unsigned STATUS_DELAY_LSB = 16;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] TRIGGER_RESET   = 32'h0000_0001;
  localparam logic [31:0] CMP_VALUE_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Comparator operators
  // ----------------------------------------------------------------------
  localparam logic [2:0] OP_EQ = 3'h0;
  localparam logic [2:0] OP_NE = 3'h1;
  localparam logic [2:0] OP_LT = 3'h2;
  localparam logic [2:0] OP_GT = 3'h3;
  localparam logic [2:0] OP_LE = 3'h4;
  localparam logic [2:0] OP_GE = 3'h5;

endpackage : logic_pkg

`default_nettype wire

// *** delay_link_if.sv ***
/*
  Link between the element engine and one delay element: logic-cycle tick,
  enable, input level, rise and fall times, and the delayed output.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface delay_link_if;
  logic                              tick;
  logic                              enable;
  logic                              level;
  logic [logic_pkg::DELAY_MS_W-1:0]  riseMs;
  logic [logic_pkg::DELAY_MS_W-1:0]  fallMs;
  logic                              held;

  modport owner   (output tick, output enable, output level, output riseMs, output fallMs, input held);
  modport element (input tick, input enable, input level, input riseMs, input fallMs, output held);
endinterface : delay_link_if

`default_nettype wire

// *** delay_element.sv ***
/*
  One on/off delay element, stepped once per logic cycle.
  Assumes tick is a one-cycle pulse per millisecond and the level is
  already synchronised to clk.
*/
`timescale 1ns/1ns
`default_nettype none

module delay_element (
  input wire logic      clk,
  input wire logic      resetn,
  delay_link_if.element link
);

  typedef struct packed {
    logic                             held;
    logic [logic_pkg::DELAY_MS_W-1:0] elapsed;
  } delay_state_type;

  delay_state_type d;
  delay_state_type next_d;
  logic [logic_pkg::DELAY_MS_W-1:0] target;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Mismatch between input and output is timed; any return of the input
  // restarts the count, so short glitches never reach the output
  always_comb begin
    next_d = d;
    target = d.held ? link.fallMs : link.riseMs;  // RULE_04
    if (!link.enable) begin
      next_d = '0;
    end else if (link.tick) begin
      if (link.level == d.held) begin
        next_d.elapsed = '0;  // RULE_15
      end else if (target == '0 || d.elapsed == target - 16'h1) begin
        next_d.held    = link.level;  // RULE_05
        next_d.elapsed = '0;
      end else begin
        next_d.elapsed = d.elapsed + 16'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      d <= '0;
    end else begin
      d <= next_d;
    end
  end

  assign link.held = d.held;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  rise_after_hold_a: assert property ($rose(d.held) |-> $past(link.level) && // RULE_05
      ($past(link.riseMs) == '0 || $past(d.elapsed) == $past(link.riseMs) - 16'h1))
    else $error("delay output rose before the rise time");
  fall_after_hold_a: assert property ($fell(d.held) && $past(link.enable) |-> // RULE_04
      ($past(link.fallMs) == '0 || $past(d.elapsed) == $past(link.fallMs) - 16'h1))
    else $error("delay output fell before the fall time");
  glitch_drop_a: assert property (link.enable && link.tick && !d.held && !link.level // RULE_15
      |=> !d.held && d.elapsed == '0)
    else $error("short input pulse was not suppressed");

endmodule : delay_element

`default_nettype wire

// *** field_side.sv ***
/*
  Field-side model for the logic elements: binary pins, front-panel button,
  measurement and delay inputs, plus the edge-to-delay cascade wiring.
  Assumes one clock; the bench sets the wanted levels just after an edge.
*/
`timescale 1ns/1ns
`default_nettype none

module field_side (
  input  wire logic        clk,
  input  wire logic        edgeOut,
  input  wire logic [7:0]  want,
  input  wire logic [31:0] wantMeas,
  input  wire logic [13:0] wantSpare,
  output logic [5:0]       pins,
  output logic [31:0]      measurement,
  output logic [15:0]      delayIn
);
  // Field levels move only on clock edges, like a scanned input card
  always_ff @(posedge clk) begin
    pins        <= want[5:0];
    measurement <= wantMeas;
    delayIn     <= {wantSpare, want[6], edgeOut};
  end
endmodule : field_side

`default_nettype wire

// *** logic_function_elements_bench.sv ***
/*
  Self-checking bench for the logic function elements.
  Assumes a 10-clock logic tick and the field-side model on the pins.
*/
`timescale 1ns/1ns
`default_nettype none

module logic_function_elements_bench;
  localparam int TICK = 10;
  logic        clk, resetn, cyc, stb, we, ack, countOut, edgeOut, latchOut, cmpOut;
  logic [31:0] adr, dat, rdat, meas, wantMeas, m, v;
  logic [3:0]  sel, wsel;
  logic [7:0]  want;
  logic [13:0] spare;
  logic [5:0]  pins;
  logic [15:0] dIn, dOut;
  logic [63:0] expq[$];
  logic        expc;
  int          miscompares, n_compared, ticks, n;
  logic [1:0]  latchTab [4] = '{2'h1, 2'h0, 2'h2, 2'h3};

  field_side partner (.clk(clk), .edgeOut(edgeOut), .want(want), .wantMeas(wantMeas), .wantSpare(spare),
    .pins(pins), .measurement(meas), .delayIn(dIn));

  logic_function_elements #(.TICK_CYCLES(TICK)) uut (.clk(clk), .resetn(resetn), .countPulseIn(pins[0]),
    .countReset(pins[1]), .edgeSource(pins[2]), .edgePolarity(pins[3]), .latchSet(pins[4]),
    .backButton(pins[5]), .measurement(meas), .delayIn(dIn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .counterOut(countOut),
    .edgeOut(edgeOut), .latchOut(latchOut), .compareOut(cmpOut), .delayOut(dOut));

  // Clock at 100 MHz
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Classic single cycle; the wait is bounded only by the timeout below
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we  <= w;
    adr <= {24'h0, a};
    dat <= d;
    sel <= wsel;
    do @(posedge clk); while (ack !== 1'h1);
    cyc <= 1'h0;
    stb <= 1'h0;
    we  <= 1'h0;
  endtask : bus

  // Note the masked expectation, then read
  task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] val);
    expq.push_back({msk, val});
    bus(1'h0, a, 32'h0);
  endtask : rd

  task automatic ms(input int k);
    repeat (k * TICK) @(posedge clk);
  endtask : ms

  // Watcher: oldest note against each read answer; status reads also check the pins
  always @(posedge clk) begin
    ticks++;
    if (ack === 1'h1 && we === 1'h0 && expq.size() > 0) begin
      check(rdat & expq[0][63:32], expq[0][31:0]);
      if (adr[7:0] === logic_pkg::STATUS_OFS)
        check({dOut, 12'h0, cmpOut, latchOut, edgeOut, countOut} & expq[0][63:32], expq[0][31:0]);
      void'(expq.pop_front());
    end
    // Whole run needs well under 5000 clocks
    if (ticks > 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    resetn = 1'h0;
    {cyc, stb, we, adr, dat, want, wantMeas} = '0;
    {sel, wsel} = 8'hff;
    miscompares = 0;
    n_compared = 0;
    ticks = 0;
    void'($urandom(1496));
    spare = 14'($urandom);
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    rd(logic_pkg::TRIGGER_OFS, 32'hffffffff, logic_pkg::TRIGGER_RESET);
    bus(1'h1, logic_pkg::COUNT_OFS, 32'h5);
    rd(logic_pkg::COUNT_OFS, 32'hffffffff, 32'h0);
    rd(8'h20, 32'hffffffff, 32'h0);
    bus(1'h1, logic_pkg::TRIGGER_OFS, 32'h3);
    bus(1'h1, logic_pkg::DELAY_EN_OFS, 32'h3);
    bus(1'h1, 8'h40, 32'h0008_0000);
    bus(1'h1, 8'h44, 32'h0002_0003);
    // Counter reaches its threshold on the third pulse, then is cleared
    for (int i = 0; i < 3; i++) begin
      want[0] <= 1'h1;
      ms(3);
      want[0] <= 1'h0;
      ms(3);
      rd(logic_pkg::COUNT_OFS, 32'hffffffff, 32'(i + 1));
      rd(logic_pkg::STATUS_OFS, 32'h1, {31'h0, i == 2});
    end
    want[1] <= 1'h1;
    ms(3);
    want[1] <= 1'h0;
    ms(2);
    rd(logic_pkg::COUNT_OFS, 32'hffffffff, 32'h0);
    rd(logic_pkg::STATUS_OFS, 32'h1, 32'h0);
    // Edge: every polarity against both transitions, pulse length in clocks
    for (int i = 0; i < 4; i++) begin
      want[3] <= (i < 2);
      ms(3);
      want[2] <= ~want[2];
      n = 0;
      repeat (120) begin
        @(posedge clk);
        if (edgeOut === 1'h1) n++;
      end
      check(32'(n), (i == 0 || i == 3) ? 32'(logic_pkg::EDGE_PULSE_TICKS * TICK) : 32'h0);
    end
    rd(logic_pkg::STATUS_OFS, 32'hffff0000, 32'h0001_0000);
    ms(15);
    rd(logic_pkg::STATUS_OFS, 32'hffff0000, 32'h0);
    // Latch: set, hold, button clear, set beats button
    for (int i = 0; i < 4; i++) begin
      want[5:4] <= latchTab[i];
      ms(3);
      rd(logic_pkg::STATUS_OFS, 32'h4, {29'h0, i != 2, 2'h0});
    end
    want[5:4] <= 2'h0;
    // Comparator: all six operators and one unused code, small signed values
    for (int op = 0; op < 7; op++) begin
      m = 32'($urandom % 5) - 32'h2;
      v = 32'($urandom % 3) - 32'h1;
      wantMeas <= m;
      bus(1'h1, logic_pkg::CMP_OP_OFS, 32'(op));
      bus(1'h1, logic_pkg::CMP_VALUE_OFS, v);
      case (op)
        0: expc = $signed(m) == $signed(v);
        1: expc = $signed(m) != $signed(v);
        2: expc = $signed(m) < $signed(v);
        3: expc = $signed(m) > $signed(v);
        4: expc = $signed(m) <= $signed(v);
        5: expc = $signed(m) >= $signed(v);
        default: expc = 1'h0;
      endcase
      ms(3);
      rd(logic_pkg::STATUS_OFS, 32'h8, {28'h0, expc, 3'h0});
    end
    // Delay slot 1: short pulse swallowed, long one delayed and stretched
    want[6] <= 1'h1;
    ms(2);
    want[6] <= 1'h0;
    ms(5);
    rd(logic_pkg::STATUS_OFS, 32'hffff0000, 32'h0);
    want[6] <= 1'h1;
    ms(5);
    rd(logic_pkg::STATUS_OFS, 32'hffff0000, 32'h0002_0000);
    want[6] <= 1'h0;
    ms(1);
    rd(logic_pkg::STATUS_OFS, 32'hffff0000, 32'h0002_0000);
    ms(4);
    rd(logic_pkg::STATUS_OFS, 32'hffff0000, 32'h0);
    // Byte lanes: only lane 1 of the trigger moves; the operator needs lane 0
    wsel = 4'h2;
    bus(1'h1, logic_pkg::TRIGGER_OFS, 32'h0000_7700);
    bus(1'h1, logic_pkg::CMP_OP_OFS, 32'h5);
    rd(logic_pkg::TRIGGER_OFS, 32'hffffffff, 32'h0000_7703);
    rd(logic_pkg::CMP_OP_OFS, 32'h7, 32'h6);
    tally_and_finish();
  end
endmodule : logic_function_elements_bench

`default_nettype wire
